// File: rtl/plrtc_control.sv
// Operation
// - quarter-rate divides main lock-detect comparison by four
// - aux clear resets aux counters, floats pump
// - main clear resets main counters, floats pump
// - power-up always applies a counter reset
// - main float floats pump, counters run
// - aux float floats pump, counters run
`timescale 1ns/1ps
`default_nettype none
`include "plrtc_params.svh"
module plrtc_control
	import plrtc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic power_up,
	input wire logic word_load,
	input wire plrtc_pkg::plrtc_word_t word_data,
	input wire logic main_cmp_pulse,
	input wire logic aux_cmp_pulse,
	output logic main_counter_reset,
	output logic aux_counter_reset,
	output logic main_pump_float,
	output logic aux_pump_float,
	output logic main_lock_cmp_pulse,
	output logic aux_lock_cmp_pulse,
	output logic word_reject
);
	plrtc_word_t loop_reset_and_float_control_reg;
	plrtc_word_t loop_reset_and_float_control_next;
	plrtc_state_t state_reg;
	plrtc_state_t state_next;
	logic main_rst_reg;
	logic main_rst_next;
	logic aux_rst_reg;
	logic aux_rst_next;
	logic main_flt_reg;
	logic main_flt_next;
	logic aux_flt_reg;
	logic aux_flt_next;
	logic aux_lock_reg;
	logic reject_reg;
	logic reject_next;
	logic word_hit;
	logic word_ok;
	logic quarter_rate;

	assign word_hit = word_load &&
		(word_data[`PLRTC_SEL_MSB:0] == `PLRTC_SEL_CODE);
	// a word with wrong fixed bits is dropped so a bad frame cannot upset the loops
	assign word_ok = word_hit &&
		((word_data & `PLRTC_FIXED_MASK) == `PLRTC_FIXED_VALUE);
	assign quarter_rate = loop_reset_and_float_control_reg[`PLRTC_QUARTER_RATE_BIT];

	always_comb begin
		loop_reset_and_float_control_next = loop_reset_and_float_control_reg;
		state_next = state_reg;
		reject_next = word_hit && !word_ok;
		case (state_reg)
			PLRTC_ST_POWER_CLEAR: begin
				// held for one cycle after power-up, whatever the word says
				state_next = PLRTC_ST_RUN;
				if (word_ok) begin
					loop_reset_and_float_control_next = word_data;
				end
			end
			PLRTC_ST_RUN: begin
				if (word_ok) begin
					loop_reset_and_float_control_next = word_data;
				end
			end
			default: begin
				state_next = PLRTC_ST_POWER_CLEAR;
			end
		endcase
		if (power_up) begin
			state_next = PLRTC_ST_POWER_CLEAR;
		end
	end

	always_comb begin
		main_rst_next = loop_reset_and_float_control_next[`PLRTC_MAIN_CLEAR_BIT];
		aux_rst_next = loop_reset_and_float_control_next[`PLRTC_AUX_CLEAR_BIT];
		if (state_next == PLRTC_ST_POWER_CLEAR) begin
			main_rst_next = 1'b1;
			aux_rst_next = 1'b1;
		end
		// a counter clear also floats that loop's pump
		main_flt_next = main_rst_next ||
			loop_reset_and_float_control_next[`PLRTC_MAIN_PUMP_FLOAT_BIT];
		aux_flt_next = aux_rst_next ||
			loop_reset_and_float_control_next[`PLRTC_AUX_PUMP_FLOAT_BIT];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			loop_reset_and_float_control_reg <= `PLRTC_RESET_WORD;
			state_reg <= PLRTC_ST_POWER_CLEAR;
			main_rst_reg <= 1'b1;
			aux_rst_reg <= 1'b1;
			main_flt_reg <= 1'b1;
			aux_flt_reg <= 1'b1;
			aux_lock_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			loop_reset_and_float_control_reg <= loop_reset_and_float_control_next;
			state_reg <= state_next;
			main_rst_reg <= main_rst_next;
			aux_rst_reg <= aux_rst_next;
			main_flt_reg <= main_flt_next;
			aux_flt_reg <= aux_flt_next;
			aux_lock_reg <= aux_cmp_pulse;
			reject_reg <= reject_next;
		end
	end

	plrtc_quarter_div u_quarter_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable_quarter(quarter_rate),
		.cmp_pulse(main_cmp_pulse),
		.lock_pulse(main_lock_cmp_pulse)
	);

	assign main_counter_reset = main_rst_reg;
	assign aux_counter_reset = aux_rst_reg;
	assign main_pump_float = main_flt_reg;
	assign aux_pump_float = aux_flt_reg;
	assign aux_lock_cmp_pulse = aux_lock_reg;
	assign word_reject = reject_reg;
endmodule : plrtc_control
`default_nettype wire

// File: rtl/plrtc_params.svh
`ifndef PLRTC_PARAMS_SVH
`define PLRTC_PARAMS_SVH

`define PLRTC_WORD_W 24
`define PLRTC_SEL_MSB 3
`define PLRTC_SEL_CODE 4'hF
`define PLRTC_MAIN_PUMP_FLOAT_BIT 4
`define PLRTC_AUX_PUMP_FLOAT_BIT 5
`define PLRTC_MAIN_CLEAR_BIT 6
`define PLRTC_AUX_CLEAR_BIT 7
`define PLRTC_ONE_BIT 11
`define PLRTC_QUARTER_RATE_BIT 13
`define PLRTC_FIXED_MASK 24'hFF_DF00
`define PLRTC_FIXED_VALUE 24'h00_0800
`define PLRTC_RESET_WORD 24'h00_080F
`define PLRTC_QUARTER_DIV 2'h3
`define PLRTC_DIV_W 2

`endif

// File: rtl/plrtc_pkg.sv
package plrtc_pkg;
	typedef logic [23:0] plrtc_word_t;
	typedef enum logic [1:0] {
		PLRTC_ST_POWER_CLEAR = 2'b00,
		PLRTC_ST_RUN = 2'b01
	} plrtc_state_t;
endpackage : plrtc_pkg

// File: rtl/plrtc_quarter_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrtc_params.svh"
module plrtc_quarter_div (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic enable_quarter,
	input wire logic cmp_pulse,
	output logic lock_pulse
);
	logic [`PLRTC_DIV_W-1:0] cnt_reg;
	logic [`PLRTC_DIV_W-1:0] cnt_next;
	logic lock_next;
	logic lock_reg;

	always_comb begin
		cnt_next = cnt_reg;
		lock_next = 1'b0;
		if (!enable_quarter) begin
			cnt_next = '0;
			lock_next = cmp_pulse;
		end else if (cmp_pulse) begin
			// one pulse passes out of every four
			if (cnt_reg == `PLRTC_QUARTER_DIV) begin
				cnt_next = '0;
				lock_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			lock_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			lock_reg <= lock_next;
		end
	end

	assign lock_pulse = lock_reg;
endmodule : plrtc_quarter_div
`default_nettype wire

// File: verification/plrtc_ctl_props.sv
`timescale 1ns/1ps
`default_nettype none
module plrtc_ctl_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic power_up,
	input wire logic word_load,
	input wire plrtc_pkg::plrtc_word_t word_data,
	input wire logic main_cmp_pulse,
	input wire logic main_counter_reset,
	input wire logic aux_counter_reset,
	input wire logic main_pump_float,
	input wire logic aux_pump_float,
	input wire logic main_lock_cmp_pulse,
	input wire logic word_reject
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic ok = word_data[3:0] == 4'hF && (word_data & 24'hFF_DF00) == 24'h00_0800;
	logic [7:0] w_reg;
	logic q_reg;
	always_ff @(posedge clk) w_reg <= word_data[7:0];
	always_ff @(posedge clk) q_reg <= sys_rst ? 1'b0 : (word_load && ok ? word_data[13] : q_reg);
	sequence s_ld; word_load && ok && !power_up; endsequence
	property p_main; s_ld |=> main_counter_reset == w_reg[6] && main_pump_float == (w_reg[6] | w_reg[4]); endproperty
	a_main: assert property (p_main) else $error("main loop control wrong");
	property p_aux; s_ld |=> aux_counter_reset == w_reg[7] && aux_pump_float == (w_reg[7] | w_reg[5]); endproperty
	a_aux: assert property (p_aux) else $error("aux loop control wrong");
	property p_pwr; power_up |=> &{main_counter_reset, aux_counter_reset, main_pump_float, aux_pump_float}; endproperty
	a_pwr: assert property (p_pwr) else $error("no clear after power-up");
	property p_bad; word_load && word_data[3:0] == 4'hF && !ok |=> word_reject; endproperty
	a_bad: assert property (p_bad) else $error("bad word not flagged");
	property p_good; s_ld |=> !word_reject; endproperty
	a_good: assert property (p_good) else $error("good word flagged");
	property p_full; !q_reg |=> main_lock_cmp_pulse == $past(main_cmp_pulse); endproperty
	a_full: assert property (p_full) else $error("undivided pulse wrong");
	property p_quad; q_reg && main_lock_cmp_pulse |=> !main_lock_cmp_pulse; endproperty
	a_quad: assert property (p_quad) else $error("divided pulse too close");
endmodule : plrtc_ctl_props
bind plrtc_control plrtc_ctl_props props_inst (.clk, .sys_rst, .power_up, .word_load, .word_data, .main_cmp_pulse,
	.main_counter_reset, .aux_counter_reset, .main_pump_float, .aux_pump_float, .main_lock_cmp_pulse, .word_reject);
`default_nettype wire

// File: verification/plrtc_host.sv
`timescale 1ns/1ps
`default_nettype none
module plrtc_host (
	input wire logic clk,
	output logic word_load,
	output var plrtc_pkg::plrtc_word_t word_data
);
	initial {word_load, word_data} = 25'h00_0000;
	task automatic send(input plrtc_pkg::plrtc_word_t w);
		@(negedge clk);
		{word_load, word_data} = {1'b1, w};
		@(negedge clk);
		// released data flips so a stale word never looks valid
		{word_load, word_data} = {1'b0, ~w};
	endtask : send
endmodule : plrtc_host
`default_nettype wire

// File: verification/test_plrtc_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_plrtc_control;
	logic clk = 1'b0, sys_rst = 1'b1, power_up = 1'b0, main_cmp_pulse = 1'b0, aux_cmp_pulse = 1'b0;
	logic word_load, main_counter_reset, aux_counter_reset, main_pump_float, aux_pump_float, word_reject;
	logic main_lock_cmp_pulse, aux_lock_cmp_pulse;
	int fail_count = 0, checks = 0;
	plrtc_pkg::plrtc_word_t word_data;
	wire logic [4:0] seen = {word_reject, main_counter_reset, aux_counter_reset, main_pump_float, aux_pump_float};
	always #5 clk = ~clk;
	plrtc_host plrtc_host_inst (.clk, .word_load, .word_data);
	plrtc_control plrtc_control_inst (.clk, .sys_rst, .power_up, .word_load, .word_data,
		.main_cmp_pulse, .aux_cmp_pulse, .main_counter_reset, .aux_counter_reset, .main_pump_float,
		.aux_pump_float, .main_lock_cmp_pulse, .aux_lock_cmp_pulse, .word_reject);
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) $display("[ERR] %0t seen %h expected %h", $time, s, e);
		fail_count += int'(s !== e);
	endtask : chk
	task automatic send(input plrtc_pkg::plrtc_word_t w, input logic [4:0] e);
		plrtc_host_inst.send(w);
		chk({3'h0, seen}, {3'h0, e});
	endtask : send
	task automatic burst(input int n, input logic [7:0] e);
		logic [3:0] m = 4'h0, a = 4'h0;
		for (int i = 0; i <= n; i++) begin
			{main_cmp_pulse, aux_cmp_pulse} = {2{i < n}};
			@(negedge clk);
			{m, a} = {m + main_lock_cmp_pulse, a + aux_lock_cmp_pulse};
		end
		chk({m, a}, e);
	endtask : burst
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		chk({3'h0, seen}, 8'h00);
		burst(4, 8'h44);
		for (int i = 0; i < 16; i++) send({16'h0008, 4'(i), 4'hF}, {1'b0, i[2], i[3], i[2] | i[0], i[3] | i[1]});
		send(24'h00_0C0F, 5'h1F);
		send(24'h00_08F7, 5'h0F);
		send(24'h00_280F, 5'h00);
		power_up = 1'b1;
		@(negedge clk);
		power_up = 1'b0;
		chk({3'h0, seen}, 8'h0F);
		@(negedge clk);
		chk({3'h0, seen}, 8'h00);
		$display("control word tests done");
		burst(8, 8'h28);
		$display("comparison rate tests done");
		complete_run();
	end
endmodule : test_plrtc_control
`default_nettype wire
